// ---- rtl/ptac_defines.vh ----
`ifndef PTAC_DEFINES_VH
`define PTAC_DEFINES_VH

// Register offsets
`define PTAC_A_AMP_CHAN 8'h00
`define PTAC_A_AMP_DB 8'h04
`define PTAC_A_AMP_AUTO 8'h08
`define PTAC_A_OFS_CHOICE 8'h0c
`define PTAC_A_OFS_NATIVE 8'h10
`define PTAC_A_OFS_PCT 8'h14
`define PTAC_A_CLAMP 8'h18
`define PTAC_A_RATIO_CHOICE 8'h1c
`define PTAC_A_RATIO_VAL 8'h20
`define PTAC_A_RATIO_AUTO 8'h24
`define PTAC_A_GAMMA 8'h28
`define PTAC_A_TONE_ON 8'h2c
`define PTAC_A_EDGE_ON 8'h30
`define PTAC_A_EDGE_AUTO 8'h34
`define PTAC_A_EDGE_AMT 8'h38
`define PTAC_A_EDGE_LIMIT 8'h3c

// Auto mode codes
`define PTAC_AUTO_OFF 2'h0
`define PTAC_AUTO_ONCE 2'h1
`define PTAC_AUTO_CONT 2'h2

// Component and colour choices
`define PTAC_OFS_ALL 2'h0
`define PTAC_OFS_ANALOG 2'h1
`define PTAC_OFS_DIGITAL 2'h2
`define PTAC_CHAN_G 2'h0
`define PTAC_CHAN_R 2'h1
`define PTAC_CHAN_B 2'h2

// Reset values and limits
`define PTAC_RST_DB 6'h00
`define PTAC_DB_MAX 6'h2f
`define PTAC_RST_RATIO 8'h40
`define PTAC_RST_GAMMA 8'h40
`define PTAC_GAMMA_ONE 10'h040
`define PTAC_RST_AMT 8'h20
// Q4.4 cannot hold +8.0, so the ceiling sits one step below it
`define PTAC_AMT_MAX 8'h7f
`define PTAC_AMT_MIN 8'hf0
`define PTAC_LIMIT_MAX 8'h40
`define PTAC_RST_LIMIT 8'h08
`define PTAC_THR_AUTO_BASE 8'h02
`define PTAC_PEAK_LOW 8'hc0
`define PTAC_PIX_MAX 8'hff

`endif

// ---- rtl/ptac_top.v ----
`timescale 1ns/1ps
`include "ptac_defines.vh"

// Overview of operation
// - Gain channel choice offers only all channels, total amplification.
// - Gain value sets signal amplification in decibels for selected channel.
// - Once gain mode performs one adjustment then returns mode to off.
// - Continuous gain adjusts every frame; auto modes maximise dynamic range.
// - Only total black level is writable; analog and digital read only.
// - Native-unit black level sets signal offset for selected component.
// - Percent black level sets the same offset in percent.
// - Clamp enable compensates dark current; unavailable on rolling shutter sensors.
// - Ratio choice is red or blue; ratio is gain relative to green.
// - White balance off is manual; once or continuous adjust ratios automatically.
// - Gamma value shapes intensity; gamma enable switches correction.
// - Sharpening enable is read-write and disabled after reset.
// - Auto sharpening derives threshold from the gain setting, ignoring user value.
// - Sharpening amount is proportional to pixel minus neighbour difference.
// - Negative amount smooths, positive boosts; boost up to 8x, smoothing 1x.
// - Sharpening amount holds a fixed-point value defaulting to 2.0.
// - Sharpen only where gradient exceeds threshold.
// - Threshold is fraction of range, accepted from zero to one quarter.
// - Total black level splits automatically into analog and digital parts.
// - Gamma raises pixel to the gamma power, after gain and white balance.
// - Once white balance runs several passes then returns to off.
module ptac_top #(
	parameter AWB_PASSES = 8,
	parameter [7:0] ANALOG_MAX = 8'h20
)(
	input wire ref_clk_in,
	input wire arst_n_in,
	input wire [7:0] addr_in,
	input wire [7:0] wr_data_in,
	input wire wr_in,
	input wire rd_in,
	output reg [7:0] rd_data_out,
	input wire [7:0] pix_in,
	input wire [7:0] nbr_in,
	input wire [1:0] chan_in,
	input wire pix_valid_in,
	input wire dark_pix_in,
	input wire frame_end_in,
	input wire rolling_shutter_in,
	output reg [7:0] pix_out,
	output reg [1:0] chan_out,
	output reg pix_valid_out,
	output reg [7:0] analog_offset_out
);

// ************************************
// Helpers
// ************************************
function [10:0] db_to_lin;
	input [5:0] db;
	reg [2:0] sh;
	reg [5:0] fr;
	reg [5:0] q;
	begin
		q = db / 6'd6;
		sh = q[2:0];
		fr = db - {sh, 1'b0} - {1'b0, sh, 2'b0};
		case (fr)
			6'd1: db_to_lin = {sh, 8'd144};
			6'd2: db_to_lin = {sh, 8'd161};
			6'd3: db_to_lin = {sh, 8'd181};
			6'd4: db_to_lin = {sh, 8'd203};
			6'd5: db_to_lin = {sh, 8'd228};
			default: db_to_lin = {sh, 8'd128};
		endcase
	end
endfunction

function [7:0] sat8;
	input signed [31:0] v;
	begin
		if (v < 0)
			sat8 = 8'h00;
		else if (v > 255)
			sat8 = `PTAC_PIX_MAX;
		else
			sat8 = v[7:0];
	end
endfunction

// ************************************
// Control state
// ************************************
reg [5:0] amp_db;
reg [1:0] amp_auto_mode;
reg [1:0] offset_component_choice;
reg [7:0] offset_total;
reg dark_current_clamp_on;
reg color_ratio_choice;
reg [7:0] ratio_r;
reg [7:0] ratio_b;
reg [1:0] color_ratio_auto_mode;
reg [7:0] gamma_val;
reg tone_curve_on;
reg edge_boost_on;
reg edge_limit_auto;
reg [7:0] edge_amt;
reg [7:0] edge_limit_user;
reg roll_s1;
reg roll_s2;
reg [7:0] dark_est;
reg [7:0] awb_pass;

wire clamp_active = dark_current_clamp_on & ~roll_s2;
wire [7:0] ofs_analog = (offset_total > ANALOG_MAX) ? ANALOG_MAX : offset_total;
wire [7:0] ofs_digital = offset_total - ofs_analog;
wire [7:0] thr_auto = {3'b000, amp_db[5:1]} + `PTAC_THR_AUTO_BASE;
wire [7:0] thr_applied = edge_limit_auto ? thr_auto : edge_limit_user;
wire [15:0] pct_to_raw = {8'h00, wr_data_in} * 16'd653;
wire [15:0] raw_to_pct = {8'h00, offset_total} * 16'd201;
wire [7:0] wr_limit = (wr_data_in > `PTAC_LIMIT_MAX) ? `PTAC_LIMIT_MAX : wr_data_in;
wire signed [7:0] wr_amt_s = wr_data_in;
wire [7:0] wr_amt = (wr_amt_s > $signed(`PTAC_AMT_MAX)) ? `PTAC_AMT_MAX :
	(wr_amt_s < $signed(`PTAC_AMT_MIN)) ? `PTAC_AMT_MIN : wr_data_in;

// ************************************
// Pipeline stage 1: sharpen and black level
// ************************************
wire signed [9:0] diff = {2'b00, pix_in} - {2'b00, nbr_in};
wire [9:0] diff_mag = diff[9] ? -diff : diff;
wire signed [19:0] boost = diff * $signed({{2{edge_amt[7]}}, edge_amt});
wire edge_hit = edge_boost_on & (diff_mag > {2'b00, thr_applied});
// Negative amounts pull the pixel toward its neighbour; -1.0 reaches it exactly
wire signed [31:0] sharp = edge_hit ? ({24'h0, pix_in} + {{16{boost[19]}}, boost[19:4]}) :
	{24'h0, pix_in};
wire [7:0] sharp8 = sat8(sharp);
wire [7:0] dark_sub = clamp_active ? dark_est : 8'h00;
wire signed [31:0] blk = {24'h0, sharp8} - {24'h0, dark_sub} + {24'h0, ofs_digital};
wire signed [9:0] dark_diff = {2'b00, pix_in} - {2'b00, dark_est};

reg [7:0] s1_pix;
reg [1:0] s1_chan;
reg s1_valid;
reg s1_fe;

always @(posedge ref_clk_in or negedge arst_n_in)
begin
	if (!arst_n_in)
	begin
		s1_pix <= 8'h00;
		s1_chan <= 2'h0;
		s1_valid <= 1'b0;
		s1_fe <= 1'b0;
		dark_est <= 8'h00;
		roll_s1 <= 1'b0;
		roll_s2 <= 1'b0;
	end
	else
	begin
		roll_s1 <= rolling_shutter_in;
		roll_s2 <= roll_s1;
		s1_pix <= sat8(blk);
		s1_chan <= chan_in;
		s1_valid <= pix_valid_in & ~dark_pix_in;
		s1_fe <= frame_end_in;
		// Slow average keeps one hot dark pixel from swinging the clamp
		if (pix_valid_in & dark_pix_in)
			dark_est <= dark_est + {{3{dark_diff[9]}}, dark_diff[7:3]};
	end
end

// ************************************
// Pipeline stage 2: gain and white balance
// ************************************
wire [10:0] lin = db_to_lin(amp_db);
wire [31:0] gained = ({24'h0, s1_pix} * {24'h0, lin[7:0]}) << lin[10:8];
wire [7:0] sel_ratio = (s1_chan == `PTAC_CHAN_R) ? ratio_r :
	(s1_chan == `PTAC_CHAN_B) ? ratio_b : `PTAC_RST_RATIO;
wire [31:0] balanced = ({7'h0, gained[31:7]} * {24'h0, sel_ratio}) >> 6;
wire [7:0] bal8 = (balanced > 32'd255) ? `PTAC_PIX_MAX : balanced[7:0];

reg [7:0] s2_pix;
reg [1:0] s2_chan;
reg s2_valid;
reg s2_fe;

always @(posedge ref_clk_in or negedge arst_n_in)
begin
	if (!arst_n_in)
	begin
		s2_pix <= 8'h00;
		s2_chan <= 2'h0;
		s2_valid <= 1'b0;
		s2_fe <= 1'b0;
	end
	else
	begin
		s2_pix <= bal8;
		s2_chan <= s1_chan;
		s2_valid <= s1_valid;
		s2_fe <= s1_fe;
	end
end

// ************************************
// Pipeline stage 3: gamma
// ************************************
// Curve bends P toward P^gamma; exact at 1.0, smooth approximation elsewhere
wire [15:0] bend_full = {8'h00, s2_pix} * {8'h00, (`PTAC_PIX_MAX - s2_pix)};
wire signed [9:0] gam_k = $signed(`PTAC_GAMMA_ONE) - $signed({2'b00, gamma_val});
wire signed [19:0] gam_adj = $signed({2'b00, bend_full[15:8]}) * gam_k;
wire signed [31:0] gam_pix = {24'h0, s2_pix} + {{18{gam_adj[19]}}, gam_adj[19:6]};

always @(posedge ref_clk_in or negedge arst_n_in)
begin
	if (!arst_n_in)
	begin
		pix_out <= 8'h00;
		chan_out <= 2'h0;
		pix_valid_out <= 1'b0;
		analog_offset_out <= 8'h00;
	end
	else
	begin
		pix_out <= tone_curve_on ? sat8(gam_pix) : s2_pix;
		chan_out <= s2_chan;
		pix_valid_out <= s2_valid;
		analog_offset_out <= ofs_analog;
	end
end

// ************************************
// Frame statistics
// ************************************
reg [7:0] frm_peak;
reg [23:0] sum_r;
reg [23:0] sum_g;
reg [23:0] sum_b;

always @(posedge ref_clk_in or negedge arst_n_in)
begin
	if (!arst_n_in)
	begin
		frm_peak <= 8'h00;
		sum_r <= 24'h0;
		sum_g <= 24'h0;
		sum_b <= 24'h0;
	end
	else if (s2_fe)
	begin
		frm_peak <= 8'h00;
		sum_r <= 24'h0;
		sum_g <= 24'h0;
		sum_b <= 24'h0;
	end
	else if (s2_valid)
	begin
		if (s2_pix > frm_peak)
			frm_peak <= s2_pix;
		if (s2_chan == `PTAC_CHAN_R)
			sum_r <= sum_r + {16'h0, s2_pix};
		else if (s2_chan == `PTAC_CHAN_B)
			sum_b <= sum_b + {16'h0, s2_pix};
		else
			sum_g <= sum_g + {16'h0, s2_pix};
	end
end

// Two greens per colour pixel in the mosaic
wire [23:0] g_half = {1'b0, sum_g[23:1]};

// ************************************
// Register writes and auto loops
// ************************************
wire amp_step = s2_fe & (amp_auto_mode != `PTAC_AUTO_OFF);
wire awb_step = s2_fe & (color_ratio_auto_mode != `PTAC_AUTO_OFF);

always @(posedge ref_clk_in or negedge arst_n_in)
begin
	if (!arst_n_in)
	begin
		amp_db <= `PTAC_RST_DB;
		amp_auto_mode <= `PTAC_AUTO_OFF;
		offset_component_choice <= `PTAC_OFS_ALL;
		offset_total <= 8'h00;
		dark_current_clamp_on <= 1'b0;
		color_ratio_choice <= 1'b0;
		ratio_r <= `PTAC_RST_RATIO;
		ratio_b <= `PTAC_RST_RATIO;
		color_ratio_auto_mode <= `PTAC_AUTO_OFF;
		gamma_val <= `PTAC_RST_GAMMA;
		tone_curve_on <= 1'b0;
		edge_boost_on <= 1'b0;
		edge_limit_auto <= 1'b0;
		edge_amt <= `PTAC_RST_AMT;
		edge_limit_user <= `PTAC_RST_LIMIT;
		awb_pass <= 8'h00;
	end
	else
	begin
		// Peak at full scale is clipping, peak low wastes range
		if (amp_step)
		begin
			if (frm_peak == `PTAC_PIX_MAX && amp_db != 6'h00)
				amp_db <= amp_db - 6'h01;
			else if (frm_peak < `PTAC_PEAK_LOW && amp_db != `PTAC_DB_MAX)
				amp_db <= amp_db + 6'h01;
			if (amp_auto_mode == `PTAC_AUTO_ONCE)
				amp_auto_mode <= `PTAC_AUTO_OFF;
		end
		if (awb_step)
		begin
			if (sum_r < g_half && ratio_r != 8'hff)
				ratio_r <= ratio_r + 8'h01;
			else if (sum_r > g_half && ratio_r != 8'h01)
				ratio_r <= ratio_r - 8'h01;
			if (sum_b < g_half && ratio_b != 8'hff)
				ratio_b <= ratio_b + 8'h01;
			else if (sum_b > g_half && ratio_b != 8'h01)
				ratio_b <= ratio_b - 8'h01;
			if (color_ratio_auto_mode == `PTAC_AUTO_ONCE)
			begin
				if (awb_pass == AWB_PASSES[7:0] - 8'h01)
				begin
					awb_pass <= 8'h00;
					color_ratio_auto_mode <= `PTAC_AUTO_OFF;
				end
				else
					awb_pass <= awb_pass + 8'h01;
			end
		end
		// Software writes come last so they win over the loops
		if (wr_in)
		begin
			if (addr_in == `PTAC_A_AMP_DB)
				amp_db <= (wr_data_in[5:0] > `PTAC_DB_MAX || wr_data_in[7:6] != 2'b00) ?
					`PTAC_DB_MAX : wr_data_in[5:0];
			else if (addr_in == `PTAC_A_AMP_AUTO)
				amp_auto_mode <= (wr_data_in[1:0] == 2'h3) ? `PTAC_AUTO_CONT : wr_data_in[1:0];
			else if (addr_in == `PTAC_A_OFS_CHOICE)
				offset_component_choice <= (wr_data_in[1:0] == 2'h3) ? `PTAC_OFS_ALL : wr_data_in[1:0];
			else if (addr_in == `PTAC_A_OFS_NATIVE)
			begin
				if (offset_component_choice == `PTAC_OFS_ALL)
					offset_total <= wr_data_in;
			end
			else if (addr_in == `PTAC_A_OFS_PCT)
			begin
				if (offset_component_choice == `PTAC_OFS_ALL)
					offset_total <= (wr_data_in > 8'd100) ? `PTAC_PIX_MAX : pct_to_raw[15:8];
			end
			else if (addr_in == `PTAC_A_CLAMP)
				dark_current_clamp_on <= wr_data_in[0];
			else if (addr_in == `PTAC_A_RATIO_CHOICE)
				color_ratio_choice <= wr_data_in[0];
			else if (addr_in == `PTAC_A_RATIO_VAL)
			begin
				if (color_ratio_choice)
					ratio_b <= wr_data_in;
				else
					ratio_r <= wr_data_in;
			end
			else if (addr_in == `PTAC_A_RATIO_AUTO)
			begin
				color_ratio_auto_mode <= (wr_data_in[1:0] == 2'h3) ? `PTAC_AUTO_CONT : wr_data_in[1:0];
				awb_pass <= 8'h00;
			end
			else if (addr_in == `PTAC_A_GAMMA)
				gamma_val <= wr_data_in;
			else if (addr_in == `PTAC_A_TONE_ON)
				tone_curve_on <= wr_data_in[0];
			else if (addr_in == `PTAC_A_EDGE_ON)
				edge_boost_on <= wr_data_in[0];
			else if (addr_in == `PTAC_A_EDGE_AUTO)
				edge_limit_auto <= wr_data_in[0];
			else if (addr_in == `PTAC_A_EDGE_AMT)
				edge_amt <= wr_amt;
			else if (addr_in == `PTAC_A_EDGE_LIMIT)
				edge_limit_user <= wr_limit;
		end
	end
end

// ************************************
// Register reads
// ************************************
reg [7:0] next_rd_data;

always @*
begin
	next_rd_data = 8'h00;
	if (addr_in == `PTAC_A_AMP_CHAN)
		next_rd_data = 8'h00;
	else if (addr_in == `PTAC_A_AMP_DB)
		next_rd_data = {2'b00, amp_db};
	else if (addr_in == `PTAC_A_AMP_AUTO)
		next_rd_data = {6'h00, amp_auto_mode};
	else if (addr_in == `PTAC_A_OFS_CHOICE)
		next_rd_data = {6'h00, offset_component_choice};
	else if (addr_in == `PTAC_A_OFS_NATIVE)
	begin
		if (offset_component_choice == `PTAC_OFS_ANALOG)
			next_rd_data = ofs_analog;
		else if (offset_component_choice == `PTAC_OFS_DIGITAL)
			next_rd_data = ofs_digital;
		else
			next_rd_data = offset_total;
	end
	else if (addr_in == `PTAC_A_OFS_PCT)
		next_rd_data = raw_to_pct[16 - 1:9] > 8'd100 ? 8'd100 : {1'b0, raw_to_pct[15:9]};
	else if (addr_in == `PTAC_A_CLAMP)
		next_rd_data = {6'h00, clamp_active, dark_current_clamp_on};
	else if (addr_in == `PTAC_A_RATIO_CHOICE)
		next_rd_data = {7'h00, color_ratio_choice};
	else if (addr_in == `PTAC_A_RATIO_VAL)
		next_rd_data = color_ratio_choice ? ratio_b : ratio_r;
	else if (addr_in == `PTAC_A_RATIO_AUTO)
		next_rd_data = {6'h00, color_ratio_auto_mode};
	else if (addr_in == `PTAC_A_GAMMA)
		next_rd_data = gamma_val;
	else if (addr_in == `PTAC_A_TONE_ON)
		next_rd_data = {7'h00, tone_curve_on};
	else if (addr_in == `PTAC_A_EDGE_ON)
		next_rd_data = {7'h00, edge_boost_on};
	else if (addr_in == `PTAC_A_EDGE_AUTO)
		next_rd_data = {7'h00, edge_limit_auto};
	else if (addr_in == `PTAC_A_EDGE_AMT)
		next_rd_data = edge_amt;
	else if (addr_in == `PTAC_A_EDGE_LIMIT)
		next_rd_data = thr_applied;
end

always @(posedge ref_clk_in or negedge arst_n_in)
begin
	if (!arst_n_in)
		rd_data_out <= 8'h00;
	else if (rd_in)
		rd_data_out <= next_rd_data;
	else
		rd_data_out <= 8'h00;
end

endmodule

// ---- tb/ptac_top_props.sv ----
`timescale 1ns/1ps
// ********
// Port checker
// ********
module ptac_props #(
	parameter [7:0] ANALOG_MAX = 8'h20
)(
	input wire ref_clk_in,
	input wire arst_n_in,
	input wire [7:0] addr_in,
	input wire [7:0] wr_data_in,
	input wire wr_in,
	input wire rd_in,
	input wire [7:0] rd_data_out,
	input wire pix_valid_in,
	input wire dark_pix_in,
	input wire rolling_shutter_in,
	input wire pix_valid_out,
	input wire [7:0] analog_offset_out
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!arst_n_in);

	property p_rd_idle;
		!rd_in |=> rd_data_out == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_chan_all;
		rd_in && addr_in == 8'h00 |=> rd_data_out == 8'h00;
	endproperty
	a_chan_all: assert property (p_chan_all) else $error("channel choice not all");
	property p_gain_range;
		rd_in && addr_in == 8'h04 |=> rd_data_out <= 8'h2f;
	endproperty
	a_gain_range: assert property (p_gain_range) else $error("gain above range");
	property p_auto_code;
		rd_in && addr_in == 8'h08 |=> rd_data_out <= 8'h02;
	endproperty
	a_auto_code: assert property (p_auto_code) else $error("bad gain mode code");
	property p_limit_range;
		rd_in && addr_in == 8'h3c |=> rd_data_out <= 8'h40;
	endproperty
	a_limit_range: assert property (p_limit_range) else $error("threshold above quarter");
	property p_analog_max;
		analog_offset_out <= ANALOG_MAX;
	endproperty
	a_analog_max: assert property (p_analog_max) else $error("analog share too large");
	// Four samples high so the two-flop synchroniser has surely settled
	property p_clamp_rolling;
		rd_in && addr_in == 8'h18 && rolling_shutter_in && $past(rolling_shutter_in)
			&& $past(rolling_shutter_in, 2) && $past(rolling_shutter_in, 3) |=> !rd_data_out[1];
	endproperty
	a_clamp_rolling: assert property (p_clamp_rolling) else $error("clamp active on rolling");
	property p_valid_pipe;
		pix_valid_in && !dark_pix_in |-> ##3 pix_valid_out;
	endproperty
	a_valid_pipe: assert property (p_valid_pipe) else $error("pixel lost in pipe");
	property p_dark_drop;
		pix_valid_in && dark_pix_in |-> ##3 !pix_valid_out;
	endproperty
	a_dark_drop: assert property (p_dark_drop) else $error("dark pixel forwarded");
	property p_edge_rw;
		wr_in && addr_in == 8'h30 ##2 rd_in && addr_in == 8'h30 |=> rd_data_out[0] == $past(wr_data_in[0], 3);
	endproperty
	a_edge_rw: assert property (p_edge_rw) else $error("sharpen enable not kept");
endmodule

bind ptac_top ptac_props #(.ANALOG_MAX(ANALOG_MAX)) u_props (
	.ref_clk_in(ref_clk_in),
	.arst_n_in(arst_n_in),
	.addr_in(addr_in),
	.wr_data_in(wr_data_in),
	.wr_in(wr_in),
	.rd_in(rd_in),
	.rd_data_out(rd_data_out),
	.pix_valid_in(pix_valid_in),
	.dark_pix_in(dark_pix_in),
	.rolling_shutter_in(rolling_shutter_in),
	.pix_valid_out(pix_valid_out),
	.analog_offset_out(analog_offset_out)
);

// ---- tb/pixel_tone_adjust_control_tb.sv ----
`timescale 1ns/1ps
module pixel_tone_adjust_control_tb;
	reg ref_clk_in = 1'b0;
	reg arst_n_in = 1'b0;
	reg [7:0] addr_in = 8'h00;
	reg [7:0] wr_data_in = 8'h00;
	reg wr_in = 1'b0;
	reg rd_in = 1'b0;
	reg [7:0] pix_in = 8'h00;
	reg [7:0] nbr_in = 8'h00;
	reg [1:0] chan_in = 2'h0;
	reg pix_valid_in = 1'b0;
	reg dark_pix_in = 1'b0;
	reg frame_end_in = 1'b0;
	reg rolling_shutter_in = 1'b0;
	wire [7:0] rd_data_out;
	wire [7:0] pix_out;
	wire [1:0] chan_out;
	wire pix_valid_out;
	wire [7:0] analog_offset_out;
	integer failures = 0;
	integer compares = 0;
	integer i;
	integer v;
	reg [7:0] amt;
	reg [7:0] p;
	reg [7:0] n;

	ptac_top #(.AWB_PASSES(2)) dut (
		.ref_clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.addr_in(addr_in),
		.wr_data_in(wr_data_in),
		.wr_in(wr_in),
		.rd_in(rd_in),
		.rd_data_out(rd_data_out),
		.pix_in(pix_in),
		.nbr_in(nbr_in),
		.chan_in(chan_in),
		.pix_valid_in(pix_valid_in),
		.dark_pix_in(dark_pix_in),
		.frame_end_in(frame_end_in),
		.rolling_shutter_in(rolling_shutter_in),
		.pix_out(pix_out),
		.chan_out(chan_out),
		.pix_valid_out(pix_valid_out),
		.analog_offset_out(analog_offset_out)
	);

	always #12.5 ref_clk_in = ~ref_clk_in;

	// ********
	// Helpers
	// ********
	task ck(input [7:0] seen, input [7:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp)
			begin
				failures = failures + 1;
				$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask

	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge ref_clk_in);
			wr_in <= 1'b1;
			addr_in <= a;
			wr_data_in <= d;
			@(posedge ref_clk_in);
			wr_in <= 1'b0;
		end
	endtask

	task rdck(input [7:0] a, input [7:0] e);
		begin
			@(posedge ref_clk_in);
			rd_in <= 1'b1;
			addr_in <= a;
			@(posedge ref_clk_in);
			rd_in <= 1'b0;
			#1;
			ck(rd_data_out, e);
		end
	endtask

	// Pixel taken at the second edge, result stands two edges later
	task px(input [7:0] pv, input [7:0] nv, input [7:0] e);
		begin
			@(posedge ref_clk_in);
			pix_in <= pv;
			nbr_in <= nv;
			pix_valid_in <= 1'b1;
			@(posedge ref_clk_in);
			pix_valid_in <= 1'b0;
			repeat (2) @(posedge ref_clk_in);
			#1;
			ck({7'h00, pix_valid_out}, 8'h01);
			ck(pix_out, e);
			ck({6'h00, chan_out}, {6'h00, chan_in});
		end
	endtask

	task frame;
		begin
			@(posedge ref_clk_in);
			frame_end_in <= 1'b1;
			@(posedge ref_clk_in);
			frame_end_in <= 1'b0;
			repeat (4) @(posedge ref_clk_in);
		end
	endtask

	function [7:0] rst_val(input [7:0] a);
		case (a)
			8'h20, 8'h28: rst_val = 8'h40;
			8'h38: rst_val = 8'h20;
			8'h3c: rst_val = 8'h08;
			default: rst_val = 8'h00;
		endcase
	endfunction

	// Amounts are whole multiples of 1.0, so truncation cannot blur the result
	function [7:0] sharp(input [7:0] pv, input [7:0] nv, input [7:0] a, input integer t);
		integer d;
		integer r;
		begin
			d = pv - nv;
			r = pv;
			if (d > t || -d > t)
				r = r + (d * $signed(a)) / 16;
			if (r < 0)
				r = 0;
			if (r > 255)
				r = 255;
			sharp = r[7:0];
		end
	endfunction

	task print_verdict;
		begin
			$display("TB: compares=%0d failures=%0d", compares, failures);
			if (failures == 0 && compares > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask

	// ********
	// Tests
	// ********
	initial
	begin
		v = $urandom(97);
		repeat (10) @(posedge ref_clk_in);
		arst_n_in <= 1'b1;
		for (i = 0; i <= 64; i = i + 4)
			rdck(i[7:0], rst_val(i[7:0]));
		ck(analog_offset_out, 8'h00);
		$display("test reset done");
		wr(8'h00, 8'h02);
		rdck(8'h00, 8'h00);
		for (i = 0; i < 9; i = i + 1)
		begin
			v = (i == 0) ? 48 : $urandom % 64;
			wr(8'h04, v[7:0]);
			rdck(8'h04, (v > 47) ? 8'h2f : v[7:0]);
		end
		for (i = 0; i < 4; i = i + 1)
		begin
			wr(8'h08, i[7:0]);
			rdck(8'h08, (i == 3) ? 8'h02 : i[7:0]);
		end
		wr(8'h08, 8'h01);
		frame;
		rdck(8'h08, 8'h00);
		rdck(8'h04, (v > 46) ? 8'h2f : v[7:0] + 8'h01);
		wr(8'h20, 8'h60);
		wr(8'h1c, 8'h01);
		rdck(8'h20, 8'h40);
		wr(8'h1c, 8'h00);
		rdck(8'h20, 8'h60);
		wr(8'h24, 8'h01);
		rdck(8'h24, 8'h01);
		frame;
		frame;
		rdck(8'h24, 8'h00);
		wr(8'h04, 8'h00);
		$display("test modes done");
		wr(8'h10, 8'h30);
		wr(8'h0c, 8'h01);
		wr(8'h10, 8'h05);
		rdck(8'h10, 8'h20);
		ck(analog_offset_out, 8'h20);
		wr(8'h0c, 8'h02);
		rdck(8'h10, 8'h10);
		wr(8'h0c, 8'h00);
		rdck(8'h10, 8'h30);
		wr(8'h14, 8'd50);
		v = 50 * 653 >> 8;
		rdck(8'h10, v[7:0]);
		v = v * 201 >> 9;
		rdck(8'h14, v[7:0]);
		wr(8'h10, 8'h00);
		@(posedge ref_clk_in);
		rolling_shutter_in <= 1'b1;
		wr(8'h18, 8'h01);
		rdck(8'h18, 8'h01);
		@(posedge ref_clk_in);
		rolling_shutter_in <= 1'b0;
		repeat (4) @(posedge ref_clk_in);
		rdck(8'h18, 8'h03);
		wr(8'h18, 8'h00);
		$display("test offset done");
		for (i = 0; i < 8; i = i + 1)
		begin
			if (i == 4)
				wr(8'h2c, 8'h01);
			p = $urandom;
			n = $urandom;
			px(p, n, p);
		end
		wr(8'h28, 8'h20);
		px(8'h00, 8'h00, 8'h00);
		px(8'hff, 8'hff, 8'hff);
		wr(8'h2c, 8'h00);
		px(8'h40, 8'h40, 8'h40);
		wr(8'h2c, 8'h01);
		repeat (3) @(posedge ref_clk_in);
		#1;
		// A power below one must lift mid tones
		ck({7'h00, pix_out > 8'h40}, 8'h01);
		wr(8'h2c, 8'h00);
		wr(8'h04, 8'h06);
		px(8'h30, 8'h30, 8'h60);
		wr(8'h04, 8'h00);
		@(posedge ref_clk_in);
		chan_in <= 2'h1;
		px(8'h40, 8'h40, 8'h60);
		@(posedge ref_clk_in);
		chan_in <= 2'h0;
		wr(8'h30, 8'h01);
		rdck(8'h30, 8'h01);
		px(8'h80, 8'h78, sharp(8'h80, 8'h78, 8'h20, 8));
		px(8'h80, 8'h77, sharp(8'h80, 8'h77, 8'h20, 8));
		px(8'hf0, 8'h10, sharp(8'hf0, 8'h10, 8'h20, 8));
		for (i = 0; i < 12; i = i + 1)
		begin
			v = $urandom % 9;
			amt = (v - 1) * 16;
			wr(8'h38, amt);
			p = $urandom;
			n = $urandom;
			px(p, n, sharp(p, n, amt, 8));
		end
		wr(8'h3c, 8'h90);
		rdck(8'h3c, 8'h40);
		wr(8'h3c, 8'h08);
		wr(8'h30, 8'h00);
		px(8'h80, 8'h40, 8'h80);
		wr(8'h30, 8'h01);
		wr(8'h38, 8'h10);
		wr(8'h34, 8'h01);
		rdck(8'h3c, 8'h02);
		px(8'h80, 8'h7d, sharp(8'h80, 8'h7d, 8'h10, 2));
		@(posedge ref_clk_in);
		pix_valid_in <= 1'b1;
		dark_pix_in <= 1'b1;
		@(posedge ref_clk_in);
		pix_valid_in <= 1'b0;
		dark_pix_in <= 1'b0;
		repeat (4) @(posedge ref_clk_in);
		// One dark sample of 0x80 moves the estimate by an eighth
		wr(8'h30, 8'h00);
		wr(8'h18, 8'h01);
		px(8'h80, 8'h80, 8'h70);
		$display("test pixel done");
		print_verdict;
	end

	initial
	begin
		repeat (20000) @(posedge ref_clk_in);
		failures = failures + 1;
		print_verdict;
	end
endmodule
